// ==== pkg/sbk_params.svh ====
// timing constants, field layout and counts for the sdram bank/cke controller
`ifndef SBK_PARAMS_SVH
`define SBK_PARAMS_SVH

`define SBK_NUM_BANKS 4
`define SBK_BA_W 2
`define SBK_CNT_W 8
`define SBK_CLK_PERIOD_NS 40
// row precharge, activate-to-column, write recovery, self refresh exit (ns)
`define SBK_TRP_NS 20
`define SBK_TRCD_NS 20
`define SBK_TWR_NS 15
`define SBK_TXSR_NS 75
// least times round up to whole cycles, never below one
`define SBK_CYC_UP(ns) (((ns) + `SBK_CLK_PERIOD_NS - 1) / `SBK_CLK_PERIOD_NS)
`define SBK_TRP_CYC `SBK_CYC_UP(`SBK_TRP_NS)
`define SBK_TRCD_CYC `SBK_CYC_UP(`SBK_TRCD_NS)
`define SBK_TWR_CYC `SBK_CYC_UP(`SBK_TWR_NS)
`define SBK_TXSR_CYC `SBK_CYC_UP(`SBK_TXSR_NS)
`define SBK_CL_DEF 3
`define SBK_BL_DEF 4
// address bit that carries auto precharge with read/write
`define SBK_AP_BIT 10
`define SBK_ADDR_W 13

`endif

// ==== pkg/sbk_pkg.sv ====
// types shared by the sdram bank/cke controller modules
package sbk_pkg;

    typedef enum logic [7:0] {
        CMD_INHIBIT = 8'h01,
        CMD_NOP = 8'h02,
        CMD_ACT = 8'h04,
        CMD_READ = 8'h08,
        CMD_WRITE = 8'h10,
        CMD_PRE = 8'h20,
        CMD_REF = 8'h40,
        CMD_OTHER = 8'h80
    } sbk_cmd_e;

    typedef enum logic [7:0] {
        BK_IDLE = 8'h01,
        BK_ACTIVATING = 8'h02,
        BK_ACTIVE = 8'h04,
        BK_READ = 8'h08,
        BK_WRITE = 8'h10,
        BK_WR_RECOVER = 8'h20,
        BK_PRECHARGING = 8'h40,
        BK_AP_WAIT = 8'h80
    } sbk_bank_e;

    typedef enum logic [4:0] {
        CK_NORMAL = 5'h01,
        CK_POWER_DOWN = 5'h02,
        CK_SELF_REFRESH = 5'h04,
        CK_SR_EXIT = 5'h08,
        CK_SUSPEND = 5'h10
    } sbk_cke_e;

endpackage

// ==== pkg/sbk_bank_if.sv ====
// command carrier from the decoder to each bank tracker
`timescale 1ns/10ps
interface sbk_bank_if;
    logic cmd_act;
    logic cmd_rw;
    logic cmd_wr;
    logic cmd_pre;
    logic ap;
    logic interrupt;
    logic busy;
    logic idle;
    sbk_pkg::sbk_bank_e state;

    modport ctrl (
        output cmd_act, cmd_rw, cmd_wr, cmd_pre, ap, interrupt,
        input busy, idle, state
    );
    modport bank (
        input cmd_act, cmd_rw, cmd_wr, cmd_pre, ap, interrupt,
        output busy, idle, state
    );
endinterface

// ==== rtl/sbk_bank.sv ====
// one bank's state tracker with timed auto precharge
`timescale 1ns/10ps
`include "sbk_params.svh"
module sbk_bank #(
    parameter int CNT_W = `SBK_CNT_W
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // burst end and stall
    input wire logic burst_done_i,
    input wire logic stall_i,
    // command carrier
    sbk_bank_if.bank cif
);
    localparam logic [CNT_W-1:0] TRP_C = CNT_W'(`SBK_TRP_CYC);
    localparam logic [CNT_W-1:0] TRCD_C = CNT_W'(`SBK_TRCD_CYC);
    localparam logic [CNT_W-1:0] TWR_C = CNT_W'(`SBK_TWR_CYC);

    initial begin
        if (CNT_W < 2) begin
            $error("sbk_bank: counter too narrow");
        end
    end

    sbk_pkg::sbk_bank_e state_reg;
    logic ap_reg;
    logic [CNT_W-1:0] cnt_reg;

    assign cif.state = state_reg;
    assign cif.idle = (state_reg == sbk_pkg::BK_IDLE);
    assign cif.busy = ap_reg;

    // ----------------------------------------------------------------
    // bank state
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= sbk_pkg::BK_IDLE;
            ap_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (!stall_i) begin
            if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            unique case (state_reg)
                sbk_pkg::BK_IDLE: begin
                    if (cif.cmd_act) begin
                        state_reg <= sbk_pkg::BK_ACTIVATING;
                        cnt_reg <= TRCD_C - 1'b1;
                    end
                end
                sbk_pkg::BK_ACTIVATING: begin
                    if (cnt_reg == '0) begin
                        state_reg <= sbk_pkg::BK_ACTIVE;
                    end
                end
                sbk_pkg::BK_ACTIVE, sbk_pkg::BK_READ, sbk_pkg::BK_WRITE: begin
                    if (cif.cmd_pre) begin
                        state_reg <= sbk_pkg::BK_PRECHARGING;
                        cnt_reg <= TRP_C - 1'b1;
                        ap_reg <= 1'b0;
                    end else if (cif.cmd_rw) begin
                        state_reg <= cif.cmd_wr ? sbk_pkg::BK_WRITE : sbk_pkg::BK_READ;
                        ap_reg <= cif.ap;
                    end else if (cif.interrupt || burst_done_i) begin
                        // an ended or interrupted auto-precharge read starts precharge now; a write recovers first
                        if (!ap_reg) begin
                            state_reg <= sbk_pkg::BK_ACTIVE;
                        end else if (state_reg == sbk_pkg::BK_WRITE) begin
                            // write recovery counted from the interrupting command
                            state_reg <= sbk_pkg::BK_WR_RECOVER;
                            cnt_reg <= TWR_C - 1'b1;
                        end else begin
                            // read: precharge from the interrupting edge
                            state_reg <= sbk_pkg::BK_AP_WAIT;
                            cnt_reg <= TRP_C - 1'b1;
                        end
                    end
                end
                sbk_pkg::BK_WR_RECOVER: begin
                    if (cnt_reg == '0) begin
                        state_reg <= sbk_pkg::BK_AP_WAIT;
                        cnt_reg <= TRP_C - 1'b1;
                    end
                end
                sbk_pkg::BK_PRECHARGING, sbk_pkg::BK_AP_WAIT: begin
                    if (cnt_reg == '0) begin
                        state_reg <= sbk_pkg::BK_IDLE;
                        ap_reg <= 1'b0;
                    end
                end
            endcase
        end
    end
endmodule

// ==== rtl/sbk_ctrl.sv ====
// four-bank command decode, burst interleave and clock-enable state machine
`timescale 1ns/10ps
`include "sbk_params.svh"
module sbk_ctrl #(
    parameter int NUM_BANKS = `SBK_NUM_BANKS,
    parameter int BA_W = `SBK_BA_W,
    parameter int ADDR_W = `SBK_ADDR_W,
    parameter int CAS_LAT = `SBK_CL_DEF,
    parameter int BURST_LEN = `SBK_BL_DEF
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // command pins
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [BA_W-1:0] ba_i,
    input wire logic [ADDR_W-1:0] addr_i,
    // data path control
    output logic rd_data_en_o,
    output logic [BA_W-1:0] rd_bank_o,
    output logic wr_data_take_o,
    output logic [BA_W-1:0] wr_bank_o,
    // status
    output logic [NUM_BANKS-1:0] bank_idle_o,
    output logic all_idle_o,
    output logic power_down_o,
    output logic self_refresh_o,
    output logic clk_suspend_o,
    output logic cmd_accept_o
);
    localparam int XSR_C = `SBK_TXSR_CYC;
    localparam int BL_W = 4;

    initial begin
        if (NUM_BANKS != (1 << BA_W)) begin
            $error("sbk_ctrl: bank count must match bank address width");
        end
        if (CAS_LAT < 1 || CAS_LAT > 7) begin
            $error("sbk_ctrl: cas latency out of range");
        end
        if (BURST_LEN < 1 || BURST_LEN > 8) begin
            $error("sbk_ctrl: burst length out of range");
        end
        if (ADDR_W <= `SBK_AP_BIT) begin
            $error("sbk_ctrl: address too narrow for auto precharge bit");
        end
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    sbk_pkg::sbk_cmd_e cmd;
    always_comb begin
        if (cs_n_i) begin
            cmd = sbk_pkg::CMD_INHIBIT;
        end else begin
            unique case ({ras_n_i, cas_n_i, we_n_i})
                3'b111: cmd = sbk_pkg::CMD_NOP;
                3'b011: cmd = sbk_pkg::CMD_ACT;
                3'b101: cmd = sbk_pkg::CMD_READ;
                3'b100: cmd = sbk_pkg::CMD_WRITE;
                3'b010: cmd = sbk_pkg::CMD_PRE;
                3'b001: cmd = sbk_pkg::CMD_REF;
                default: cmd = sbk_pkg::CMD_OTHER;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // clock-enable state machine
    // ----------------------------------------------------------------
    sbk_pkg::sbk_cke_e ck_reg;
    logic cke_prev_reg;
    logic [7:0] xsr_reg;
    logic burst_on_reg;
    logic all_idle;
    logic nop_like;
    logic live;

    assign nop_like = (cmd == sbk_pkg::CMD_INHIBIT) || (cmd == sbk_pkg::CMD_NOP);
    // commands count only in normal state with cke high on both edges
    assign live = (ck_reg == sbk_pkg::CK_NORMAL) && cke_prev_reg && cke_i;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cke_prev_reg <= 1'b0;
        end else begin
            cke_prev_reg <= cke_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ck_reg <= sbk_pkg::CK_NORMAL;
            xsr_reg <= 8'h00;
        end else begin
            unique case (ck_reg)
                sbk_pkg::CK_NORMAL: begin
                    if (cke_prev_reg && !cke_i) begin
                        if (all_idle && nop_like) begin
                            ck_reg <= sbk_pkg::CK_POWER_DOWN;
                        end else if (all_idle && cmd == sbk_pkg::CMD_REF) begin
                            ck_reg <= sbk_pkg::CK_SELF_REFRESH;
                        end else if (burst_on_reg) begin
                            ck_reg <= sbk_pkg::CK_SUSPEND;
                        end
                    end
                end
                sbk_pkg::CK_POWER_DOWN: begin
                    // banks idle for the following edge
                    if (cke_i && nop_like) begin
                        ck_reg <= sbk_pkg::CK_NORMAL;
                    end
                end
                sbk_pkg::CK_SELF_REFRESH: begin
                    if (cke_i && nop_like) begin
                        ck_reg <= sbk_pkg::CK_SR_EXIT;
                        xsr_reg <= 8'(XSR_C - 1);
                    end
                end
                sbk_pkg::CK_SR_EXIT: begin
                    if (xsr_reg == 8'h00) begin
                        ck_reg <= sbk_pkg::CK_NORMAL;
                    end else begin
                        xsr_reg <= xsr_reg - 8'h01;
                    end
                end
                sbk_pkg::CK_SUSPEND: begin
                    // exit edge takes no command; next edge is live
                    if (cke_i) begin
                        ck_reg <= sbk_pkg::CK_NORMAL;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bank trackers
    // ----------------------------------------------------------------
    sbk_bank_if bif [NUM_BANKS] ();
    logic [NUM_BANKS-1:0] idle_vec;
    logic stall;
    logic burst_done;
    logic [BA_W-1:0] cur_bank_reg;
    logic cur_wr_reg;
    logic is_rw;

    // suspend freezes internal timing and burst progress
    assign stall = (ck_reg == sbk_pkg::CK_SUSPEND) || (burst_on_reg && !cke_i);
    assign is_rw = live && (cmd == sbk_pkg::CMD_READ || cmd == sbk_pkg::CMD_WRITE);

    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_bank
            logic hit;
            assign hit = (ba_i == BA_W'(g));
            // per-bank acceptance regardless of other banks' states
            assign bif[g].cmd_act = live && hit && cmd == sbk_pkg::CMD_ACT;
            assign bif[g].cmd_rw = is_rw && hit;
            assign bif[g].cmd_wr = cmd == sbk_pkg::CMD_WRITE;
            // precharge of another bank leaves this burst running
            assign bif[g].cmd_pre = live && cmd == sbk_pkg::CMD_PRE
                && (hit || addr_i[`SBK_AP_BIT]);
            assign bif[g].ap = addr_i[`SBK_AP_BIT];
            // burst to another bank interrupts this bank's burst
            assign bif[g].interrupt = is_rw && !hit && burst_on_reg
                && cur_bank_reg == BA_W'(g);
            assign idle_vec[g] = bif[g].idle;

            sbk_bank #(
                .CNT_W(`SBK_CNT_W)
            ) u_bank (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .burst_done_i(burst_done && cur_bank_reg == BA_W'(g)),
                .stall_i(stall),
                .cif(bif[g])
            );
        end
    endgenerate

    // power-down and self-refresh entry only honoured with every bank idle
    assign all_idle = &idle_vec;

    // ----------------------------------------------------------------
    // burst sequencing; newest burst owns the data path
    // ----------------------------------------------------------------
    logic [BL_W-1:0] beat_reg;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            burst_on_reg <= 1'b0;
            cur_bank_reg <= '0;
            cur_wr_reg <= 1'b0;
            beat_reg <= '0;
        end else if (is_rw) begin
            // new burst cuts the current one at registration
            burst_on_reg <= 1'b1;
            cur_bank_reg <= ba_i;
            cur_wr_reg <= (cmd == sbk_pkg::CMD_WRITE);
            beat_reg <= BL_W'(BURST_LEN - 1);
        end else if (live && cmd == sbk_pkg::CMD_PRE
            && (ba_i == cur_bank_reg || addr_i[`SBK_AP_BIT])) begin
            burst_on_reg <= 1'b0;
        end else if (burst_on_reg && !stall) begin
            if (beat_reg == '0) begin
                burst_on_reg <= 1'b0;
            end else begin
                beat_reg <= beat_reg - 1'b1;
            end
        end
    end
    assign burst_done = burst_on_reg && !stall && beat_reg == '0 && !is_rw;

    // ----------------------------------------------------------------
    // data path timing
    // ----------------------------------------------------------------
    // write data take pulses once per write, on the clock after the write registers;
    // later beats of the burst raise no take pulse
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wr_data_take_o <= 1'b0;
            wr_bank_o <= '0;
        end else begin
            wr_data_take_o <= live && cmd == sbk_pkg::CMD_WRITE;
            wr_bank_o <= ba_i;
        end
    end

    // read pipeline: each read's output window opens CL after registration
    logic [CAS_LAT-1:0] rd_pipe_reg;
    logic [BA_W-1:0] rd_bank_pipe_reg [CAS_LAT];
    logic rd_issue;
    // the command edge is beat one, so the last counted slot adds none
    assign rd_issue = (burst_on_reg && !cur_wr_reg && !stall && beat_reg != '0)
        || (is_rw && cmd == sbk_pkg::CMD_READ);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_pipe_reg <= '0;
            for (int i = 0; i < CAS_LAT; i++) begin
                rd_bank_pipe_reg[i] <= '0;
            end
        end else if (!stall) begin
            // a write cuts the read at its registration
            rd_pipe_reg[0] <= rd_issue && !(is_rw && cmd == sbk_pkg::CMD_WRITE);
            rd_bank_pipe_reg[0] <= is_rw ? ba_i : cur_bank_reg;
            for (int i = 1; i < CAS_LAT; i++) begin
                rd_pipe_reg[i] <= rd_pipe_reg[i-1];
                rd_bank_pipe_reg[i] <= rd_bank_pipe_reg[i-1];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_data_en_o <= 1'b0;
            rd_bank_o <= '0;
        end else begin
            rd_data_en_o <= rd_pipe_reg[CAS_LAT-1] && !stall;
            rd_bank_o <= rd_bank_pipe_reg[CAS_LAT-1];
        end
    end

    // ----------------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            bank_idle_o <= '1;
            all_idle_o <= 1'b1;
            power_down_o <= 1'b0;
            self_refresh_o <= 1'b0;
            clk_suspend_o <= 1'b0;
            cmd_accept_o <= 1'b0;
        end else begin
            bank_idle_o <= idle_vec;
            all_idle_o <= all_idle;
            power_down_o <= ck_reg == sbk_pkg::CK_POWER_DOWN;
            self_refresh_o <= ck_reg == sbk_pkg::CK_SELF_REFRESH || ck_reg == sbk_pkg::CK_SR_EXIT;
            clk_suspend_o <= ck_reg == sbk_pkg::CK_SUSPEND;
            cmd_accept_o <= live && !nop_like;
        end
    end
endmodule

// ==== test/sbk_ctrl_checker.sv ====
// port assertions for the bank and clock-enable controller
`timescale 1ns/10ps
module sbk_ctrl_checker #(
    parameter int NUM_BANKS = 4,
    parameter int BA_W = 2,
    parameter int CAS_LAT = 3
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // command pins
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [BA_W-1:0] ba_i,
    // watched outputs
    input wire logic rd_data_en_o,
    input wire logic wr_data_take_o,
    input wire logic [BA_W-1:0] wr_bank_o,
    input wire logic [NUM_BANKS-1:0] bank_idle_o,
    input wire logic all_idle_o,
    input wire logic power_down_o,
    input wire logic self_refresh_o,
    input wire logic clk_suspend_o,
    input wire logic cmd_accept_o
);
    // ----
    // helper state
    // ----
    // upper bound leaves room for a short clock suspend inside the latency
    localparam int RD_LO = CAS_LAT;
    localparam int RD_HI = CAS_LAT + 6;
    logic cke_reg;
    logic live;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cke_reg <= 1'b0;
        end else begin
            cke_reg <= cke_i;
        end
    end
    assign live = cke_i && cke_reg && !cs_n_i && !power_down_o && !self_refresh_o
        && !clk_suspend_o;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // assertions
    // ----
    reset_idle_a: assert property (disable iff (1'b0) !rst_n_i ##1 !rst_n_i |->
        bank_idle_o == {NUM_BANKS{1'b1}} && all_idle_o && !power_down_o && !cmd_accept_o)
        else $error("outputs not cleared by reset");
    inhibit_quiet_a: assert property (cs_n_i |=> !cmd_accept_o)
        else $error("deselected edge was accepted");
    nop_quiet_a: assert property (!cs_n_i && ras_n_i && cas_n_i && we_n_i |=> !cmd_accept_o)
        else $error("no-op edge was accepted");
    cke_low_quiet_a: assert property (!cke_i |=> !cmd_accept_o)
        else $error("command taken with clock enable low");
    write_take_a: assert property (live && ras_n_i && !cas_n_i && !we_n_i |=>
        wr_data_take_o && cmd_accept_o && wr_bank_o == $past(ba_i))
        else $error("write not registered");
    read_data_a: assert property (live && ras_n_i && !cas_n_i && we_n_i |->
        ##[RD_LO:RD_HI] rd_data_en_o)
        else $error("read data never enabled");
    pd_hold_a: assert property (power_down_o && !cke_i |=> power_down_o)
        else $error("power-down left with clock enable low");
    pd_idle_a: assert property (power_down_o |-> all_idle_o)
        else $error("power-down with a busy bank");
    sr_idle_a: assert property (self_refresh_o |-> all_idle_o)
        else $error("self refresh with a busy bank");
    susp_hold_a: assert property (clk_suspend_o && !cke_i |=> clk_suspend_o)
        else $error("suspend left with clock enable low");
    pd_seen_c: cover property (power_down_o);
    sr_seen_c: cover property (self_refresh_o);
    susp_seen_c: cover property (clk_suspend_o);
    rd_seen_c: cover property (rd_data_en_o);
endmodule

bind sbk_ctrl sbk_ctrl_checker #(.NUM_BANKS(NUM_BANKS), .BA_W(BA_W), .CAS_LAT(CAS_LAT)) chk_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
    .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .ba_i(ba_i),
    .rd_data_en_o(rd_data_en_o), .wr_data_take_o(wr_data_take_o), .wr_bank_o(wr_bank_o),
    .bank_idle_o(bank_idle_o), .all_idle_o(all_idle_o), .power_down_o(power_down_o),
    .self_refresh_o(self_refresh_o), .clk_suspend_o(clk_suspend_o),
    .cmd_accept_o(cmd_accept_o));

// ==== test/sbk_ctl_model.sv ====
// memory controller model that drives the command pins
`timescale 1ns/10ps
module sbk_ctl_model (
    // clock
    input wire logic sys_clk_i,
    // command pins
    output logic cke_o,
    output logic cs_n_o,
    output logic [2:0] rcw_o,
    output logic [1:0] ba_o,
    output logic [12:0] addr_o
);
    integer seed = 32'h148c;
    logic [3:0] row_open;
    initial begin
        cke_o = 1'b0;
        cs_n_o = 1'b1;
        rcw_o = 3'b111;
        ba_o = 2'b00;
        addr_o = 13'h0000;
        row_open = 4'h0;
    end
    function automatic logic [31:0] rnd();
        return $random(seed);
    endfunction
    // only listed commands; refresh only with all rows closed, no burst terminate
    task automatic issue(input logic [2:0] rcw, input logic [1:0] ba, input logic ap,
                         input logic cke);
        @(negedge sys_clk_i);
        cke_o = cke;
        cs_n_o = 1'b0;
        rcw_o = rcw;
        ba_o = ba;
        addr_o = {2'(rnd()), ap, 10'(rnd())};
        if (rcw == 3'b011) begin
            row_open[ba] = 1'b1;
        end else if (rcw == 3'b010) begin
            row_open = ap ? 4'h0 : (row_open & ~(4'h1 << ba));
        end
    endtask
    // deselected pins flip so stale values never look held
    task automatic deselect(input logic cke, input int n);
        repeat (n) begin
            @(negedge sys_clk_i);
            cke_o = cke;
            cs_n_o = 1'b1;
            rcw_o = ~rcw_o;
            ba_o = ~ba_o;
            addr_o = ~addr_o;
        end
    endtask
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the bank and clock-enable controller
`timescale 1ns/10ps
module tb_top;
    localparam logic [2:0] ACT = 3'b011;
    localparam logic [2:0] RD = 3'b101;
    localparam logic [2:0] WR = 3'b100;
    localparam logic [2:0] PRE = 3'b010;
    localparam logic [2:0] REF = 3'b001;
    localparam logic [2:0] NOP = 3'b111;
    localparam int BL = 4;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cke, cs_n;
    logic [2:0] rcw;
    logic [1:0] ba, rd_bank, wr_bank, b0, b1, last_rd_bank;
    logic [12:0] addr;
    logic rd_en, wr_take, all_idle, pdn, sref, susp, acc;
    logic [3:0] bank_idle;
    int err_count = 0, compares = 0, cyc = 0, beats = 0, takes = 0, accepts = 0;
    int exp_beats = 0, exp_takes = 0, exp_acc = 0, last_rd = -100, gap;
    logic [1:0] rdq[$];
    always #20 sys_clk_i = ~sys_clk_i;
    sbk_ctl_model sbk_ctl_model_i (.sys_clk_i(sys_clk_i), .cke_o(cke), .cs_n_o(cs_n),
        .rcw_o(rcw), .ba_o(ba), .addr_o(addr));
    sbk_ctrl sbk_ctrl_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cke_i(cke),
        .cs_n_i(cs_n), .ras_n_i(rcw[2]), .cas_n_i(rcw[1]), .we_n_i(rcw[0]), .ba_i(ba),
        .addr_i(addr), .rd_data_en_o(rd_en), .rd_bank_o(rd_bank), .wr_data_take_o(wr_take),
        .wr_bank_o(wr_bank), .bank_idle_o(bank_idle), .all_idle_o(all_idle),
        .power_down_o(pdn), .self_refresh_o(sref), .clk_suspend_o(susp), .cmd_accept_o(acc));
    // ----
    // monitor and shared tasks
    // ----
    always @(posedge sys_clk_i) begin
        cyc++;
        if (rd_en === 1'b1) begin
            beats++;
            last_rd_bank = rd_bank;
        end
        if (wr_take === 1'b1) takes++;
        if (acc === 1'b1) accepts++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic op(input logic [2:0] c, input logic [1:0] b, input logic ap);
        sbk_ctl_model_i.issue(c, b, ap, 1'b1);
        exp_acc++;
        if (c == WR) exp_takes++;
        if (c == RD) begin
            // a newer read cuts the older burst at its own data slot
            gap = cyc - last_rd;
            if (gap < BL) exp_beats -= BL - gap;
            exp_beats += BL;
            last_rd = cyc;
            rdq.push_back(b);
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_count++;
        summarize();
    end
    // ----
    // main sequence
    // ----
    initial begin
        repeat (8) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        check(bank_idle, 4'hf);
        check({all_idle, pdn, sref, susp, rd_en, wr_take, acc}, 7'h40);
        sbk_ctl_model_i.deselect(1'b1, 3);
        for (int i = 0; i < 4; i++) op(ACT, 2'(i), 1'b0);
        sbk_ctl_model_i.deselect(1'b1, 3);
        check(bank_idle, 4'h0);
        $display("activate test done");
        b0 = 2'(sbk_ctl_model_i.rnd());
        b1 = b0 + 2'd1;
        op(RD, b0, 1'b0);
        op(RD, b1, 1'b0);
        sbk_ctl_model_i.deselect(1'b1, 10);
        check(beats, exp_beats);
        check(last_rd_bank, rdq[$]);
        $display("read interleave test done");
        op(WR, b0, 1'b0);
        op(WR, b1, 1'b0);
        op(RD, b0, 1'b0);
        sbk_ctl_model_i.deselect(1'b1, 10);
        check(takes, exp_takes);
        check(beats, exp_beats);
        $display("write interleave test done");
        op(RD, b0, 1'b1);
        op(RD, b1, 1'b0);
        sbk_ctl_model_i.deselect(1'b1, 6);
        check(bank_idle[b0], 1'b1);
        check(bank_idle[b1], 1'b0);
        op(ACT, b0, 1'b0);
        sbk_ctl_model_i.deselect(1'b1, 2);
        op(WR, b0, 1'b1);
        op(RD, b1, 1'b0);
        sbk_ctl_model_i.deselect(1'b1, 1);
        check(bank_idle[b0], 1'b0);
        sbk_ctl_model_i.deselect(1'b1, 7);
        check(bank_idle[b0], 1'b1);
        check(beats, exp_beats);
        $display("auto precharge test done");
        op(PRE, b0, 1'b1);
        sbk_ctl_model_i.deselect(1'b1, 4);
        check({bank_idle, all_idle}, 5'h1f);
        sbk_ctl_model_i.deselect(1'b0, 5);
        check(pdn, 1'b1);
        sbk_ctl_model_i.issue(ACT, b0, 1'b0, 1'b0);
        sbk_ctl_model_i.deselect(1'b0, 2);
        check(pdn, 1'b1);
        sbk_ctl_model_i.deselect(1'b1, 3);
        check({pdn, bank_idle}, 5'h0f);
        $display("power-down test done");
        sbk_ctl_model_i.issue(REF, 2'b00, 1'b0, 1'b0);
        sbk_ctl_model_i.deselect(1'b0, 5);
        check(sref, 1'b1);
        for (int i = 0; i < 3; i++) sbk_ctl_model_i.issue(NOP, 2'b00, 1'b0, 1'b1);
        sbk_ctl_model_i.deselect(1'b1, 3);
        check({sref, all_idle}, 2'b01);
        $display("self refresh test done");
        op(ACT, b1, 1'b0);
        sbk_ctl_model_i.deselect(1'b1, 2);
        op(RD, b1, 1'b0);
        sbk_ctl_model_i.deselect(1'b0, 3);
        check(susp, 1'b1);
        sbk_ctl_model_i.deselect(1'b1, 10);
        check({susp, 28'(beats)}, {1'b0, 28'(exp_beats)});
        check(accepts, exp_acc);
        $display("clock suspend test done");
        summarize();
    end
endmodule
